// File: src/rcc_defines.svh
`ifndef RCC_DEFINES_SVH
`define RCC_DEFINES_SVH

`define RCC_CFG_START_BIT 0
`define RCC_CFG_LOOP_HI 15
`define RCC_CFG_LOOP_LO 9
`define RCC_STATUS_STAGE_BIT 28
`define RCC_ERR_TIMEOUT 4'hf
`define RCC_ERR_NO_WINDOW 4'h1
`define RCC_ERR_NONE 4'h0
`define RCC_NUM_BYTES 8
`define RCC_TAP_MAX 6'h3f
`define RCC_RD_TIMEOUT_NS 2560
`define RCC_CLK_NS 10
`define RCC_RD_TIMEOUT_CYC (`RCC_RD_TIMEOUT_NS / `RCC_CLK_NS)
`define RCC_BURST_BEATS 4

`endif

// File: src/rcc_pkg.sv
package rcc_pkg;
   typedef enum logic [2:0] {
      RCC_IDLE = 3'h0,
      RCC_WRITE = 3'h1,
      RCC_READ = 3'h3,
      RCC_WAIT = 3'h2,
      RCC_STEP = 3'h6,
      RCC_NEXT = 3'h7,
      RCC_DONE = 3'h5,
      RCC_FAIL = 3'h4
   } rcc_state_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [2:0] byte_sel;
      logic [63:0] wdata;
      logic [7:0] wmask;
   } rcc_cmd_t;

   typedef struct packed {
      logic [63:0] rd_data;
      logic [63:0] exp_data;
      logic [63:0] err_log;
      logic [15:0] config_word;
      logic [1:0] status;
      logic [2:0] cmp_byte;
      logic rd_valid;
   } rcc_dbg_t;
endpackage

// File: src/rcc_read_complex_cal.sv
`include "rcc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module rcc_read_complex_cal
   import rcc_pkg::*;
(
   // fabric clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // control
   input wire logic cal_start,
   input wire logic [6:0] loop_count,
   // link side, memory read return domain
   input wire logic link_clk,
   input wire logic link_rst_b,
   input wire logic link_rd_valid,
   input wire logic [63:0] link_rd_data,
   // memory command port
   output rcc_cmd_t mem_cmd,
   output logic [7:0] write_data_mask,
   // status
   output logic [31:0] cal_status,
   output logic cal_done,
   output logic cal_fail,
   output logic [3:0] err_code,
   output logic [2:0] err_byte,
   output logic [5:0] tap_out,
   output logic [5:0] left_edge,
   output logic [5:0] right_edge,
   // debug
   output rcc_dbg_t dbg
);
   localparam logic [5:0] TAP_MAX = `RCC_TAP_MAX;
   localparam logic [11:0] TMO = 12'(`RCC_RD_TIMEOUT_CYC);

   rcc_state_t state_q;
   logic [2:0] byte_q;
   logic [6:0] loops_q;
   logic [5:0] tap_q;
   logic [1:0] beat_q;
   logic [11:0] tmo_q;
   logic edge_seen_q;
   logic [63:0] pat_q;
   logic [63:0] err_q;
   logic [63:0] rd_q;
   logic rdv_q;
   logic start_q;
   logic fail_q;
   logic [1:0] stat_q;
   logic [15:0] cfg_q;
   logic [3:0] code_q;
   logic [2:0] ebyte_q;
   logic [5:0] left_q;
   logic [5:0] right_q;
   rcc_cmd_t cmd_q;
   logic done_q;

   // link domain: capture word and toggle per return
   logic [63:0] lk_data_q;
   logic lk_tog_q;
   always_ff @(posedge link_clk or negedge link_rst_b) begin
      if (!link_rst_b) begin
         lk_data_q <= 64'h0;
         lk_tog_q <= 1'b0;
      end else if (link_rd_valid) begin
         lk_data_q <= link_rd_data;
         lk_tog_q <= ~lk_tog_q;
      end
   end

   // toggle synchroniser into fabric domain
   logic tog_s1_q;
   logic tog_s2_q;
   logic tog_s3_q;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tog_s1_q <= 1'b0;
         tog_s2_q <= 1'b0;
         tog_s3_q <= 1'b0;
      end else begin
         tog_s1_q <= lk_tog_q;
         tog_s2_q <= tog_s1_q;
         tog_s3_q <= tog_s2_q;
      end
   end
   wire logic rd_evt = tog_s2_q ^ tog_s3_q;

   // start input synchroniser
   logic st_s1_q;
   logic st_s2_q;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_s1_q <= 1'b0;
         st_s2_q <= 1'b0;
      end else begin
         st_s1_q <= cal_start;
         st_s2_q <= st_s1_q;
      end
   end

   // loop count synchroniser, one flip-flop pair per bit
   logic [6:0] lc_s1_q;
   logic [6:0] lc_s2_q;
   for (genvar gi = 0; gi < 7; gi++) begin : g_lc_sync
      always_ff @(posedge clk or negedge rst_b) begin
         if (!rst_b) begin
            lc_s1_q[gi] <= 1'b0;
            lc_s2_q[gi] <= 1'b0;
         end else begin
            lc_s1_q[gi] <= loop_count[gi];
            lc_s2_q[gi] <= lc_s1_q[gi];
         end
      end
   end

   // expected pattern: alternating stress word per beat and byte
   function automatic logic [63:0] exp_word(input logic [1:0] beat,
                                            input logic [2:0] byt);
      logic [63:0] w;
      w = {8{8'h33}} ^ {64{beat[0]}};
      w = w ^ {{61{1'b0}}, byt} ^ {{32{beat[1]}}, 32'h0};
      return w;
   endfunction

   // mismatch bits within the byte under test
   function automatic logic [63:0] byte_mask(input logic [2:0] byt);
      return 64'hff << {byt, 3'h0};
   endfunction

   logic [63:0] exp_now;
   logic [63:0] diff;
   logic [63:0] diff_b;
   logic one_bit;
   logic wholesale;
   always_comb begin
      exp_now = exp_word(beat_q, byte_q);
      diff = lk_data_q ^ exp_now;
      diff_b = diff & byte_mask(byte_q);
      one_bit = (diff_b != 64'h0) && ((diff_b & (diff_b - 64'h1)) == 64'h0);
      wholesale = (diff_b != 64'h0) && !one_bit;
   end
   // a beat counts only while the sequencer waits for one
   wire logic take_beat = (state_q == RCC_WAIT) && rd_evt;

   // main sequencer
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= RCC_IDLE;
         byte_q <= 3'h0;
         loops_q <= 7'h0;
         tap_q <= 6'h0;
         beat_q <= 2'h0;
         tmo_q <= 12'h0;
         edge_seen_q <= 1'b0;
         left_q <= 6'h0;
         right_q <= 6'h0;
         start_q <= 1'b0;
      end else begin
         case (state_q)
            RCC_IDLE: begin
               if (st_s2_q && !fail_q) begin
                  start_q <= 1'b1;
                  byte_q <= 3'h0;
                  tap_q <= 6'h0;
                  beat_q <= 2'h0;
                  edge_seen_q <= 1'b0;
                  loops_q <= lc_s2_q;
                  state_q <= RCC_WRITE;
               end
            end
            RCC_WRITE: begin
               beat_q <= beat_q + 2'h1;
               if (beat_q == 2'(`RCC_BURST_BEATS - 1)) begin
                  state_q <= RCC_READ;
               end
            end
            RCC_READ: begin
               tmo_q <= 12'h0;
               state_q <= RCC_WAIT;
            end
            RCC_WAIT: begin
               tmo_q <= tmo_q + 12'h1;
               if (take_beat && wholesale) begin
                  state_q <= RCC_FAIL;
               end else if (rd_evt) begin
                  beat_q <= beat_q + 2'h1;
                  if (one_bit) begin
                     if (!edge_seen_q) left_q <= tap_q;
                     edge_seen_q <= 1'b1;
                     right_q <= tap_q;
                  end
                  if (beat_q == 2'(`RCC_BURST_BEATS - 1)) begin
                     state_q <= (loops_q <= 7'h1) ? RCC_STEP : RCC_READ;
                     loops_q <= loops_q - 7'h1;
                  end
               end else if (tmo_q >= TMO) begin
                  state_q <= RCC_FAIL;
               end
            end
            RCC_STEP: begin
               loops_q <= lc_s2_q;
               if (tap_q == TAP_MAX) begin
                  state_q <= RCC_NEXT;
               end else begin
                  tap_q <= tap_q + 6'h1;
                  state_q <= RCC_READ;
               end
            end
            RCC_NEXT: begin
               tap_q <= 6'h0;
               edge_seen_q <= 1'b0;
               if (byte_q == 3'(`RCC_NUM_BYTES - 1)) begin
                  state_q <= RCC_DONE;
               end else begin
                  byte_q <= byte_q + 3'h1;
                  beat_q <= 2'h0;
                  state_q <= RCC_WRITE;
               end
            end
            RCC_DONE: begin
               if (!st_s2_q) begin
                  start_q <= 1'b0;
                  state_q <= RCC_IDLE;
               end
            end
            RCC_FAIL: begin
               state_q <= RCC_FAIL;
            end
            default: state_q <= RCC_IDLE;
         endcase
      end
   end

   // failure report, sticky until reset; a wholesale beat ends the stage
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fail_q <= 1'b0;
         code_q <= `RCC_ERR_NONE;
         ebyte_q <= 3'h0;
      end else if ((state_q == RCC_WAIT) && !fail_q) begin
         if (take_beat && wholesale) begin
            code_q <= `RCC_ERR_NO_WINDOW;
            ebyte_q <= byte_q;
            fail_q <= 1'b1;
         end else if (!rd_evt && (tmo_q >= TMO)) begin
            code_q <= `RCC_ERR_TIMEOUT;
            ebyte_q <= byte_q;
            fail_q <= 1'b1;
         end
      end
   end

   // error log, rd data capture and valid strobe
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         err_q <= 64'h0;
         rd_q <= 64'h0;
         pat_q <= 64'h0;
         rdv_q <= 1'b0;
      end else begin
         rdv_q <= take_beat;
         if (take_beat) begin
            rd_q <= lk_data_q;
            pat_q <= exp_now;
            if (wholesale) begin
               err_q <= {64{1'b1}};
            end else begin
               err_q <= diff_b;
            end
         end else if (state_q == RCC_NEXT) begin
            err_q <= 64'h0;
         end
      end
   end

   // status word, config and memory commands
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stat_q <= 2'h0;
         cfg_q <= 16'h0;
         cmd_q <= '0;
      end else begin
         cfg_q <= 16'h0;
         cfg_q[`RCC_CFG_LOOP_HI:`RCC_CFG_LOOP_LO] <= loops_q;
         cfg_q[`RCC_CFG_START_BIT] <= (state_q == RCC_READ) ||
                                      (state_q == RCC_WAIT);
         case (state_q)
            RCC_WRITE, RCC_READ, RCC_WAIT, RCC_STEP: stat_q <= 2'h1;
            default: stat_q <= 2'h0;
         endcase
         cmd_q.wr <= (state_q == RCC_WRITE);
         cmd_q.rd <= (state_q == RCC_READ) || (state_q == RCC_FAIL);
         cmd_q.byte_sel <= byte_q;
         cmd_q.wdata <= exp_word(beat_q, byte_q);
         cmd_q.wmask <= 8'h00;
      end
   end

   // completion flag, registered so the output comes from a flip-flop
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         done_q <= 1'b0;
      end else begin
         done_q <= (state_q == RCC_DONE);
      end
   end

   always_comb begin
      cal_status = 32'h0;
      cal_status[`RCC_STATUS_STAGE_BIT] = start_q;
   end

   assign mem_cmd = cmd_q;
   assign write_data_mask = cmd_q.wmask;
   assign cal_done = done_q;
   assign cal_fail = fail_q;
   assign err_code = code_q;
   assign err_byte = ebyte_q;
   assign tap_out = tap_q;
   assign left_edge = left_q;
   assign right_edge = right_q;
   assign dbg.rd_data = rd_q;
   assign dbg.exp_data = pat_q;
   assign dbg.err_log = err_q;
   assign dbg.config_word = cfg_q;
   assign dbg.status = stat_q;
   assign dbg.cmp_byte = byte_q;
   assign dbg.rd_valid = rdv_q;
endmodule
`default_nettype wire

// File: tb/rcc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module rcc_mem_model
   import rcc_pkg::*;
(
   // clocks and reset
   input wire logic clk,
   input wire logic rst_b,
   input wire logic link_clk,
   // commands; mode 1 edge bit, 2 inverted, 3 silent
   input wire rcc_cmd_t mem_cmd,
   input wire logic [5:0] tap_out,
   input wire logic [1:0] mode,
   input wire logic [3:0] lat,
   // read return
   output logic link_rd_valid,
   output logic [63:0] link_rd_data
);
   logic [63:0] mem [4];
   logic [63:0] w;
   logic [1:0] widx;
   logic [2:0] sel;
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         widx <= 2'h0;
      end else if (mem_cmd.wr) begin
         mem[widx] <= mem_cmd.wdata;
         widx <= widx + 2'h1;
      end
   end
   // idle data shows the inverse of the last beat
   initial begin
      link_rd_valid = 1'b0;
      link_rd_data = 64'h0;
      forever begin
         @(posedge clk);
         if (mem_cmd.rd && mode != 2'h3) begin
            sel = mem_cmd.byte_sel;
            // a reset cuts the burst short so no beat outlives it
            for (int j = 0; j < lat && rst_b; j++) @(posedge link_clk);
            for (int i = 0; i < 4 && rst_b; i++) begin
               w = (mode == 2'h2) ? ~mem[i] : mem[i];
               if (mode == 2'h1 && (tap_out < 6'h8 || tap_out > 6'h28))
                  w = w ^ (64'h1 << {sel, 3'h0});
               @(posedge link_clk);
               link_rd_valid <= 1'b1;
               link_rd_data <= w;
            end
            @(posedge link_clk);
            link_rd_valid <= 1'b0;
            link_rd_data <= ~w;
         end
      end
   end
endmodule
`default_nettype wire

// File: tb/rcc_props.sv
`timescale 1ns/1ps
`default_nettype none
module rcc_props
   import rcc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // watched ports
   input wire logic cal_start,
   input wire rcc_cmd_t mem_cmd,
   input wire logic [7:0] write_data_mask,
   input wire logic [31:0] cal_status,
   input wire logic cal_fail,
   input wire logic [3:0] err_code,
   input wire logic [2:0] err_byte,
   input wire rcc_dbg_t dbg
);
   logic [63:0] diff;
   assign diff = (dbg.rd_data ^ dbg.exp_data) >> {dbg.cmp_byte, 3'h0};
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_launch;
      $rose(cal_start) && !cal_fail && !cal_status[28];
   endsequence
   sequence s_bad_beat;
      dbg.rd_valid && $countones(diff[7:0]) > 1;
   endsequence
   property p_rise;
      s_launch |-> ##3 cal_status[28];
   endproperty
   a_rise: assert property (p_rise) else $error("stage bit late");
   property p_mask;
      write_data_mask == 8'h0 && mem_cmd.wmask == 8'h0;
   endproperty
   a_mask: assert property (p_mask) else $error("mask active");
   property p_busy;
      mem_cmd.wr |-> dbg.status == 2'h1;
   endproperty
   a_busy: assert property (p_busy) else $error("status low");
   property p_step;
      !$stable(dbg.cmp_byte) |-> dbg.cmp_byte == $past(dbg.cmp_byte) + 3'h1;
   endproperty
   a_step: assert property (p_step) else $error("byte skipped");
   property p_edge;
      dbg.err_log != '1 |-> $onehot0(dbg.err_log);
   endproperty
   a_edge: assert property (p_edge) else $error("log not one bit");
   property p_whole;
      s_bad_beat |-> ##[0:2] dbg.err_log == '1;
   endproperty
   a_whole: assert property (p_whole) else $error("log not full");
   property p_reads;
      cal_fail |-> ##[0:3] mem_cmd.rd;
   endproperty
   a_reads: assert property (p_reads) else $error("reads stopped");
   property p_tmo;
      $rose(err_code == 4'hf) |-> ##[0:1] cal_fail && err_byte == dbg.cmp_byte;
   endproperty
   a_tmo: assert property (p_tmo) else $error("timeout report");
endmodule
bind rcc_read_complex_cal rcc_props u_props (.clk(clk), .rst_b(rst_b),
   .cal_start(cal_start), .mem_cmd(mem_cmd), .dbg(dbg),
   .write_data_mask(write_data_mask), .cal_status(cal_status),
   .cal_fail(cal_fail), .err_code(err_code), .err_byte(err_byte));
`default_nettype wire

// File: tb/rcc_read_complex_cal_bench.sv
`timescale 1ns/1ps
`default_nettype none
module rcc_read_complex_cal_bench
   import rcc_pkg::*;
;
   logic clk = 1'b0, link_clk = 1'b0, rst_b = 1'b0, link_rst_b = 1'b0;
   logic cal_start = 1'b0, link_rd_valid, cal_done, cal_fail;
   logic [1:0] mode = 2'h1;
   logic [3:0] lat = 4'h2, err_code;
   logic [63:0] link_rd_data;
   logic [7:0] write_data_mask;
   logic [31:0] cal_status;
   logic [2:0] err_byte;
   logic [5:0] tap_out, left_edge, right_edge;
   rcc_cmd_t mem_cmd;
   rcc_dbg_t dbg;
   int error_cnt = 0, comparisons = 0, n;
   always #5 clk = ~clk;
   always #24 link_clk = ~link_clk;
   rcc_read_complex_cal DUT (.clk(clk), .rst_b(rst_b), .cal_start(cal_start),
      .loop_count(7'h2), .link_clk(link_clk), .link_rst_b(link_rst_b),
      .link_rd_valid(link_rd_valid), .link_rd_data(link_rd_data),
      .mem_cmd(mem_cmd), .write_data_mask(write_data_mask), .dbg(dbg),
      .cal_status(cal_status), .cal_done(cal_done), .cal_fail(cal_fail),
      .err_code(err_code), .err_byte(err_byte), .tap_out(tap_out),
      .left_edge(left_edge), .right_edge(right_edge));
   rcc_mem_model u_mem (.clk(clk), .rst_b(rst_b), .link_clk(link_clk),
      .mem_cmd(mem_cmd), .tap_out(tap_out), .mode(mode), .lat(lat),
      .link_rd_valid(link_rd_valid), .link_rd_data(link_rd_data));
   task automatic check(input string what, input logic [63:0] exp, got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic give_verdict();
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic do_reset(input logic [1:0] m, input logic [3:0] l);
      @(negedge clk);
      rst_b = 1'b0;
      link_rst_b = 1'b0;
      cal_start = 1'b0;
      mode = m;
      lat = l;
      repeat (5) @(negedge clk);
      repeat (2) @(posedge link_clk);
      @(negedge clk);
      rst_b = 1'b1;
      link_rst_b = 1'b1;
      @(negedge clk);
   endtask
   task automatic launch();
      cal_start = 1'b1;
      for (n = 0; n < 8 && cal_status[28] !== 1'b1; n++) @(negedge clk);
      check("stage bit", 64'h1, cal_status[28]);
   endtask
   task automatic fail_reads();
      int k;
      for (n = 0; n < 3000 && cal_fail !== 1'b1; n++) @(negedge clk);
      check("fail", 64'h1, cal_fail);
      k = 0;
      repeat (16) begin
         @(negedge clk);
         k += int'(mem_cmd.rd);
      end
      check("reads", 64'h1, k > 8);
   endtask
   initial begin
      #500us;
      error_cnt++;
      give_verdict();
   end
   initial begin
      do_reset(2'h1, 4'h2);
      check("mask", 64'h0, write_data_mask);
      check("cal status", 64'h0, cal_status);
      launch();
      check("byte", 64'h0, dbg.cmp_byte);
      for (n = 0; n < 400 && dbg.rd_valid !== 1'b1; n++) @(negedge clk);
      check("diff", 64'h1, dbg.rd_data ^ dbg.exp_data);
      check("config", 64'h401, dbg.config_word);
      check("status", 64'h1, dbg.status);
      @(negedge clk);
      check("log", 64'h1, dbg.err_log);
      for (n = 0; n < 20000 && dbg.cmp_byte !== 3'h1; n++) @(negedge clk);
      check("next byte", 64'h1, dbg.cmp_byte);
      check("status idle", 64'h0, dbg.status);
      check("left", 64'h0, left_edge);
      check("right", 64'h3f, right_edge);
      check("no fail", 64'h0, cal_fail);
      do_reset(2'h2, 4'h9);
      launch();
      fail_reads();
      check("code", 64'h1, err_code);
      check("log", ~64'h0, dbg.err_log);
      check("diff", ~64'h0, dbg.rd_data ^ dbg.exp_data);
      do_reset(2'h3, 4'h2);
      launch();
      fail_reads();
      check("code", 64'hf, err_code);
      check("err byte", 64'h0, err_byte);
      check("done", 64'h0, cal_done);
      check("status fail", 64'h0, dbg.status);
      give_verdict();
   end
endmodule
`default_nettype wire
